// ---- hdl/mwp_top.v ----
// Purpose: address paging windows, extended address pins, chip selects
// Assumes: cpu_addr, cpu_access and mode inputs come from logic on hclk
// Notes: translation and decode are combinational from registers
`timescale 1ns/1ps
`include "mwp_defs.vh"

module mwp_top (
	input wire hclk,
	input wire hresetn,
	input wire ce,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output wire [31:0] hrdata,
	input wire expanded_mode,
	input wire [4:0] reg_block_base,
	input wire [15:0] cpu_addr,
	input wire cpu_access,
	output wire [5:0] ext_addr_mid,
	input wire [6:0] port_f_in,
	output wire [6:0] port_f_out,
	output wire [6:0] port_f_oe,
	input wire [5:0] port_g_in,
	output wire [5:0] port_g_out,
	output wire [5:0] port_g_oe,
	output wire [6:0] select_onehot
);

// Software-visible registers
reg [7:0] fdata_ff;
reg [7:0] gdata_ff;
reg [7:0] fdir_ff;
reg [7:0] gdir_ff;
reg [7:0] dwpg_ff;
reg [7:0] pwpg_ff;
reg [7:0] ewpg_ff;
reg [7:0] wena_ff;
reg [7:0] pasgn_ff;
reg [7:0] sctl_ff;
reg [7:0] sctl1_ff;
reg [7:0] wloc_ff;
reg [6:0] lastsel_ff;
reg [11:0] lastadr_ff;

// Next values of the writable registers
reg [7:0] nxt_fdata;
reg [7:0] nxt_gdata;
reg [7:0] nxt_fdir;
reg [7:0] nxt_gdir;
reg [7:0] nxt_dwpg;
reg [7:0] nxt_pwpg;
reg [7:0] nxt_ewpg;
reg [7:0] nxt_wena;
reg [7:0] nxt_pasgn;
reg [7:0] nxt_sctl;
reg [7:0] nxt_sctl1;
reg [7:0] nxt_wloc;

// Bus pipeline
reg wr_pend_ff;
reg [7:0] wr_idx_ff;
reg [31:0] hrdata_ff;
reg [31:0] nxt_hrdata;

// Pin synchroniser stages
reg [6:0] f_s1_ff;
reg [6:0] f_s2_ff;
reg [5:0] g_s1_ff;
reg [5:0] g_s2_ff;

// Combinational results
reg [7:0] rd_val;
reg [21:10] xa;
reg [6:0] raw;
reg [6:0] sel;

wire [7:0] idx;
wire adr_ok;
wire take;
wire in_blk;
wire in_regs;
wire in_area;
wire in_dw;
wire in_pw;
wire in_ew;
wire dw_on;
wire pw_on;
wire ew_on;
wire act;
wire [6:0] own_f;
wire [5:0] own_g;
wire [7:0] f_view;
wire [7:0] g_view;

// Bus side: zero wait states; ce low stalls the data phase
assign hreadyout = ce;
assign hresp = 1'b0;
assign hrdata = hrdata_ff;
// Whole-word registers, so byte lanes are never decoded
assign idx = haddr[9:2];
assign adr_ok = (haddr[31:10] == `MWP_ADR_HI_ZERO);
assign take = hsel & htrans[1] & hready;

// Write commits in the data phase
// Unimplemented bits are masked, so they always read zero
always @* begin
	nxt_fdata = fdata_ff;
	nxt_gdata = gdata_ff;
	nxt_fdir = fdir_ff;
	nxt_gdir = gdir_ff;
	nxt_dwpg = dwpg_ff;
	nxt_pwpg = pwpg_ff;
	nxt_ewpg = ewpg_ff;
	nxt_wena = wena_ff;
	nxt_pasgn = pasgn_ff;
	nxt_sctl = sctl_ff;
	nxt_sctl1 = sctl1_ff;
	nxt_wloc = wloc_ff;
	if (wr_pend_ff) begin
		case (wr_idx_ff)
		`MWP_IDX_FDATA: nxt_fdata = hwdata[7:0] & `MWP_MSK_F;
		`MWP_IDX_GDATA: nxt_gdata = hwdata[7:0] & `MWP_MSK_G;
		`MWP_IDX_FDIR: nxt_fdir = hwdata[7:0] & `MWP_MSK_F;
		`MWP_IDX_GDIR: nxt_gdir = hwdata[7:0] & `MWP_MSK_G;
		`MWP_IDX_DWPG: nxt_dwpg = hwdata[7:0];
		`MWP_IDX_PWPG: nxt_pwpg = hwdata[7:0];
		`MWP_IDX_EWPG: nxt_ewpg = hwdata[7:0];
		`MWP_IDX_WENA: nxt_wena = hwdata[7:0] & `MWP_MSK_WENA;
		`MWP_IDX_PASGN: nxt_pasgn = hwdata[7:0] & `MWP_MSK_G;
		`MWP_IDX_SCTL: nxt_sctl = hwdata[7:0] & `MWP_MSK_SCTL;
		`MWP_IDX_SCTL1: nxt_sctl1 = hwdata[7:0] & `MWP_MSK_SCTL1;
		`MWP_IDX_WLOC: nxt_wloc = hwdata[7:0] & `MWP_MSK_WLOC;
		default: nxt_fdata = fdata_ff;
		endcase
	end
end

// Port reads: output bits show the latch, input bits the pin
// Input bits lag the pin by the two synchroniser stages
assign f_view = (nxt_fdir & nxt_fdata) | (~nxt_fdir & {1'b0, f_s2_ff});
assign g_view = (nxt_gdir & nxt_gdata) | (~nxt_gdir & {2'b00, g_s2_ff});

// Read mux uses next values so a write just before is seen
always @* begin
	rd_val = `MWP_RST_ZERO;
	case (idx)
	`MWP_IDX_LASTSEL: rd_val = {1'b0, lastsel_ff};
	`MWP_IDX_LASTADR: rd_val = {2'b00, lastadr_ff[11:6]};
	`MWP_IDX_FDATA: rd_val = f_view;
	`MWP_IDX_GDATA: rd_val = g_view;
	`MWP_IDX_FDIR: rd_val = nxt_fdir;
	`MWP_IDX_GDIR: rd_val = nxt_gdir;
	`MWP_IDX_DWPG: rd_val = nxt_dwpg;
	`MWP_IDX_PWPG: rd_val = nxt_pwpg;
	`MWP_IDX_EWPG: rd_val = nxt_ewpg;
	`MWP_IDX_WENA: rd_val = nxt_wena;
	`MWP_IDX_PASGN: rd_val = nxt_pasgn;
	`MWP_IDX_SCTL: rd_val = nxt_sctl;
	`MWP_IDX_SCTL1: rd_val = nxt_sctl1;
	`MWP_IDX_WLOC: rd_val = nxt_wloc;
	default: rd_val = `MWP_RST_ZERO;
	endcase
end

// Read data registered at the address edge, valid in the data phase
always @* begin
	nxt_hrdata = hrdata_ff;
	if (take & ~hwrite) begin
		nxt_hrdata = adr_ok ? {24'h000000, rd_val} : 32'h00000000;
	end
end

// Bus state and registers
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		wr_pend_ff <= 1'b0;
		wr_idx_ff <= `MWP_RST_ZERO;
		hrdata_ff <= 32'h00000000;
		fdata_ff <= `MWP_RST_ZERO;
		gdata_ff <= `MWP_RST_ZERO;
		fdir_ff <= `MWP_RST_ZERO;
		gdir_ff <= `MWP_RST_ZERO;
		dwpg_ff <= `MWP_RST_ZERO;
		pwpg_ff <= `MWP_RST_ZERO;
		ewpg_ff <= `MWP_RST_ZERO;
		wena_ff <= `MWP_RST_ZERO;
		pasgn_ff <= `MWP_RST_ZERO;
		sctl_ff <= `MWP_RST_SCTL;
		sctl1_ff <= `MWP_RST_ZERO;
		wloc_ff <= `MWP_RST_ZERO;
	end else if (ce) begin
		wr_pend_ff <= take & hwrite & adr_ok;
		wr_idx_ff <= idx;
		hrdata_ff <= nxt_hrdata;
		fdata_ff <= nxt_fdata;
		gdata_ff <= nxt_gdata;
		fdir_ff <= nxt_fdir;
		gdir_ff <= nxt_gdir;
		dwpg_ff <= nxt_dwpg;
		pwpg_ff <= nxt_pwpg;
		ewpg_ff <= nxt_ewpg;
		wena_ff <= nxt_wena;
		pasgn_ff <= nxt_pasgn;
		sctl_ff <= nxt_sctl;
		sctl1_ff <= nxt_sctl1;
		wloc_ff <= nxt_wloc;
	end
end

// Pin synchronisers for readback only
// Pins are asynchronous to hclk; no select or address logic reads them
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		f_s1_ff <= 7'h00;
		f_s2_ff <= 7'h00;
		g_s1_ff <= 6'h00;
		g_s2_ff <= 6'h00;
	end else if (ce) begin
		f_s1_ff <= port_f_in;
		f_s2_ff <= f_s1_ff;
		g_s1_ff <= port_g_in;
		g_s2_ff <= g_s1_ff;
	end
end

// Window hits
// A window whose enable bit is clear leaves its range unpaged
assign dw_on = wena_ff[`MWP_WEN_DATA];
assign pw_on = wena_ff[`MWP_WEN_PROG];
assign ew_on = wena_ff[`MWP_WEN_EXTRA];
assign in_dw = (cpu_addr[15:12] == `MWP_DWIN_TOP);
assign in_pw = (cpu_addr[15:14] == `MWP_PWIN_TOP);
assign in_ew = wloc_ff[`MWP_WLOC_BIT] ?
	(cpu_addr[15:10] == `MWP_EWIN_LO) :
	(cpu_addr[15:10] == `MWP_EWIN_HI);

// Register block and the select area right above it
assign in_blk = (cpu_addr[15:11] == reg_block_base);
assign in_regs = in_blk & (cpu_addr[10:9] == `MWP_REGS_BLK);
assign in_area = in_blk & (cpu_addr[10:9] == `MWP_SELS_BLK);

// Translation, combinational so a page write hits the next access
// Windows never overlap, so testing the extra window first is free
always @* begin
	xa = {`MWP_UNPAGED, cpu_addr[15:10]};
	if (ew_on & in_ew) begin
		xa = {`MWP_FORCE4, ewpg_ff};
	end else if (dw_on & in_dw) begin
		xa = {`MWP_FORCE2, dwpg_ff, cpu_addr[11:10]};
	end else if (pw_on & in_pw) begin
		xa = {pwpg_ff, cpu_addr[13:10]};
	end
end

assign ext_addr_mid = xa[15:10];

// Raw select ranges before precedence
// Split mode reads translated line 21, which is one outside the window
always @* begin
	raw = 7'h00;
	if (sctl1_ff[`MWP_S1_FOLLOWEXT]) begin
		raw[`MWP_SEL_THREE] = ew_on & in_ew;
	end else begin
		raw[`MWP_SEL_THREE] = in_area &
			(cpu_addr[9:7] == `MWP_SEL3_OFS);
	end
	raw[`MWP_SEL_TWO] = in_area &
		(cpu_addr[9:7] == `MWP_SEL2_OFS);
	raw[`MWP_SEL_ONE] = in_area &
		(cpu_addr[9:8] == `MWP_SEL1_OFS);
	raw[`MWP_SEL_ZERO] = in_area;
	if (sctl1_ff[`MWP_S1_HALFMAP]) begin
		raw[`MWP_SEL_DATA] = ~cpu_addr[15];
	end else begin
		raw[`MWP_SEL_DATA] = in_dw;
	end
	if (sctl1_ff[`MWP_S1_SPLIT21]) begin
		raw[`MWP_SEL_PROG0] = cpu_addr[15] & xa[21];
		raw[`MWP_SEL_PROG1] = cpu_addr[15] & ~xa[21];
	end else begin
		raw[`MWP_SEL_PROG0] = cpu_addr[15];
		raw[`MWP_SEL_PROG1] = cpu_addr[15] |
			sctl1_ff[`MWP_S1_FULLMAP];
	end
	raw = raw & sctl_ff[6:0];
end

// External selects only in expanded mode, never on the registers
// Register block outranks every external space
assign act = expanded_mode & cpu_access & ~in_regs;

// Fixed precedence leaves at most one select active
always @* begin
	sel = 7'h00;
	if (act) begin
		if (raw[`MWP_SEL_THREE]) begin
			sel[`MWP_SEL_THREE] = 1'b1;
		end else if (raw[`MWP_SEL_TWO]) begin
			sel[`MWP_SEL_TWO] = 1'b1;
		end else if (raw[`MWP_SEL_ONE]) begin
			sel[`MWP_SEL_ONE] = 1'b1;
		end else if (raw[`MWP_SEL_ZERO]) begin
			sel[`MWP_SEL_ZERO] = 1'b1;
		end else if (raw[`MWP_SEL_PROG0]) begin
			sel[`MWP_SEL_PROG0] = 1'b1;
		end else if (raw[`MWP_SEL_DATA]) begin
			sel[`MWP_SEL_DATA] = 1'b1;
		end else if (raw[`MWP_SEL_PROG1]) begin
			sel[`MWP_SEL_PROG1] = 1'b1;
		end
	end
end

// Active-high copy of the select pins, for watching from outside
assign select_onehot = sel;

// Last external access, for software to inspect
// Single-chip accesses are not recorded; no select or port G address reaches the pins then
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		lastsel_ff <= 7'h00;
		lastadr_ff <= 12'h000;
	end else if (ce & cpu_access & expanded_mode) begin
		lastsel_ff <= sel;
		lastadr_ff <= xa;
	end
end

// Port F: select takes over pin only in expanded mode
// Combinational, so the pin frames the same cycle as the address
assign own_f = {7{expanded_mode}} & sctl_ff[6:0];
assign port_f_out = (own_f & ~sel) |
	(~own_f & fdata_ff[6:0]);
assign port_f_oe = own_f | fdir_ff[6:0];

// Port G: assigned lines carry the extended address only in expanded mode
// Unassigned lines fall back to port latch and direction bit
assign own_g = {6{expanded_mode}} & pasgn_ff[5:0];
assign port_g_out = (own_g & xa[21:16]) |
	(~own_g & gdata_ff[5:0]);
assign port_g_oe = own_g | gdir_ff[5:0];

endmodule // mwp_top

// ---- inc/mwp_defs.vh ----
// Purpose: constants for the memory window paging and chip select block
// Assumes: register byte address is four times the register index
// Notes: definitions only
`ifndef MWP_DEFS_VH
`define MWP_DEFS_VH

// Register indices, byte address = index * 4
`define MWP_IDX_LASTSEL 8'h2E
`define MWP_IDX_LASTADR 8'h2F
`define MWP_IDX_FDATA 8'h30
`define MWP_IDX_GDATA 8'h31
`define MWP_IDX_FDIR 8'h32
`define MWP_IDX_GDIR 8'h33
`define MWP_IDX_DWPG 8'h34
`define MWP_IDX_PWPG 8'h35
`define MWP_IDX_EWPG 8'h36
`define MWP_IDX_WENA 8'h37
`define MWP_IDX_PASGN 8'h38
`define MWP_IDX_SCTL 8'h3C
`define MWP_IDX_SCTL1 8'h3D
`define MWP_IDX_WLOC 8'h3E
`define MWP_ADR_HI_ZERO 22'h000000

// Implemented bits of each register
`define MWP_MSK_F 8'h7F
`define MWP_MSK_G 8'h3F
`define MWP_MSK_WENA 8'hE0
`define MWP_MSK_SCTL 8'h7F
`define MWP_MSK_SCTL1 8'h78
`define MWP_MSK_WLOC 8'h80

// Reset values
`define MWP_RST_ZERO 8'h00
`define MWP_RST_SCTL 8'h20

// Window enable bits
`define MWP_WEN_DATA 7
`define MWP_WEN_PROG 6
`define MWP_WEN_EXTRA 5
// Select control 1 bits
`define MWP_S1_FULLMAP 6
`define MWP_S1_SPLIT21 5
`define MWP_S1_HALFMAP 4
`define MWP_S1_FOLLOWEXT 3
// Window location bit
`define MWP_WLOC_BIT 7

// Select numbering: control bit, port F pin and one-hot position
`define MWP_SEL_ZERO 0
`define MWP_SEL_ONE 1
`define MWP_SEL_TWO 2
`define MWP_SEL_THREE 3
`define MWP_SEL_DATA 4
`define MWP_SEL_PROG0 5
`define MWP_SEL_PROG1 6

// Address decode values
`define MWP_DWIN_TOP 4'h7
`define MWP_PWIN_TOP 2'b10
`define MWP_EWIN_LO 6'h00
`define MWP_EWIN_HI 6'h01
`define MWP_REGS_BLK 2'b00
`define MWP_SELS_BLK 2'b01
`define MWP_SEL3_OFS 3'b101
`define MWP_SEL2_OFS 3'b111
`define MWP_SEL1_OFS 2'b11
`define MWP_UNPAGED 6'h3F
`define MWP_FORCE4 4'hF
`define MWP_FORCE2 2'b11

`endif

// ---- tb/mwp_ext_mem.sv ----
// Purpose: far side of port F and port G pins
// Assumes: external parts only listen to selects and address
// Notes: released pins read high through pull-ups
`timescale 1ns/1ps
module mwp_ext_mem (
	input wire [6:0] port_f_out,
	input wire [6:0] port_f_oe,
	input wire [5:0] port_g_out,
	input wire [5:0] port_g_oe,
	output wire [6:0] f_pin,
	output wire [5:0] g_pin
);
	// Pull-up, so a released pin never shows stale data
	assign f_pin = port_f_out | ~port_f_oe;
	assign g_pin = port_g_out | ~port_g_oe;
endmodule // mwp_ext_mem

// ---- tb/mwp_props.sv ----
// Purpose: assertions on select outputs and port F pins
// Assumes: selects are combinational from cpu_addr and registers
// Notes: bound into mwp_top
`timescale 1ns/1ps
module mwp_props (
	input wire hclk,
	input wire hresetn,
	input wire expanded_mode,
	input wire [4:0] reg_block_base,
	input wire [15:0] cpu_addr,
	input wire cpu_access,
	input wire [6:0] port_f_out,
	input wire [6:0] port_f_oe,
	input wire [6:0] select_onehot
);
	wire blk = cpu_addr[15:11] == reg_block_base;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	pin_low_a: assert property (select_onehot != 7'h00 |->
		((port_f_out | ~port_f_oe) & select_onehot) == 7'h00)
		else $error("select pin not low");
	one_select_a: assert property ($onehot0(select_onehot))
		else $error("two selects");
	single_chip_a: assert property (!expanded_mode |->
		select_onehot == 7'h00) else $error("select in single chip");
	idle_bus_a: assert property (!cpu_access |->
		select_onehot == 7'h00) else $error("select with no access");
	prog_half_a: assert property (select_onehot[5] |->
		cpu_addr[15]) else $error("prog0 outside upper half");
	data_half_a: assert property (select_onehot[4] |->
		!cpu_addr[15]) else $error("data select in upper half");
	sel_two_a: assert property (select_onehot[2] |->
		blk && cpu_addr[10:7] == 4'h7) else $error("sel2 range");
	sel_zero_a: assert property (select_onehot[0] |->
		blk && cpu_addr[10:9] == 2'b01) else $error("sel0 range");
	reg_block_a: assert property (blk && cpu_addr[10:9] == 2'b00 |->
		select_onehot == 7'h00) else $error("select in register block");
endmodule // mwp_props

bind mwp_top mwp_props u_props (.hclk, .hresetn, .expanded_mode,
	.reg_block_base, .cpu_addr, .cpu_access, .port_f_out, .port_f_oe,
	.select_onehot);

// ---- tb/mwp_top_tb_top.sv ----
// Purpose: register, paging and select checks for mwp_top
// Assumes: one slave, hready taken from hreadyout
// Notes: register block base fixed at 0800
`timescale 1ns/1ps
`include "mwp_defs.vh"
module mwp_top_tb_top;
	logic hclk = 0;
	logic hresetn = 0;
	logic ce = 1;
	logic [31:0] haddr = 0;
	logic [1:0] htrans = 0;
	logic hwrite = 0;
	logic [31:0] hwdata = 0;
	logic expanded_mode = 1;
	logic [15:0] cpu_addr = 0;
	logic cpu_access = 0;
	wire hreadyout;
	wire hresp;
	wire [31:0] hrdata;
	wire [5:0] ext_addr_mid, port_g_out, port_g_oe, g_pin;
	wire [6:0] port_f_out, port_f_oe, select_onehot, f_pin;
	int n_mismatch = 0;
	int checks = 0;
	logic [15:0] pa [6] = '{16'h0A80, 16'h0B80, 16'h0B00, 16'h0A00,
		16'h0900, 16'h0C00};
	logic [6:0] ps [6] = '{7'h08, 7'h04, 7'h02, 7'h01, 7'h00, 7'h00};
	always #25 hclk = ~hclk;
	mwp_top uut (.hclk, .hresetn, .ce, .hsel(1'b1), .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
		.hresp, .hrdata, .expanded_mode, .reg_block_base(5'h01),
		.cpu_addr, .cpu_access, .ext_addr_mid, .port_f_in(f_pin),
		.port_f_out, .port_f_oe, .port_g_in(g_pin), .port_g_out,
		.port_g_oe, .select_onehot);
	mwp_ext_mem far (.port_f_out, .port_f_oe, .port_g_out, .port_g_oe,
		.f_pin, .g_pin);
	task complete_run;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value %s exp %h seen %h", nm, e, s);
		end
	endtask
	task wt;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			n_mismatch++;
			complete_run;
		end
	endtask
	task bus(input [7:0] i, input w, input [7:0] d);
		haddr <= {22'h0, i, 2'b00};
		hwrite <= w;
		htrans <= 2'b10;
		wt;
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		wt;
	endtask
	task wr(input [7:0] i, input [7:0] d);
		bus(i, 1'b1, d);
	endtask
	task rd(input [7:0] i, input [7:0] e);
		bus(i, 1'b0, 8'h00);
		chk("reg", hrdata, {24'h0, e});
		chk("resp", {31'h0, hresp}, 32'h0);
	endtask
	task ca(input [15:0] a, input [6:0] s, input [5:0] m, input [5:0] g);
		cpu_addr <= a;
		@(negedge hclk);
		chk("sel", select_onehot, s);
		chk("mid", ext_addr_mid, m);
		chk("g", port_g_out, g);
		chk("pin", (port_f_out | ~port_f_oe) & s, 32'h0);
		@(posedge hclk);
	endtask
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		rd(`MWP_IDX_FDIR, 8'h00);
		rd(`MWP_IDX_SCTL, `MWP_RST_SCTL);
		rd(8'h39, 8'h00);
		wr(`MWP_IDX_PASGN, 8'h3F);
		wr(`MWP_IDX_FDIR, 8'hFF);
		wr(`MWP_IDX_FDATA, 8'h7F);
		wr(`MWP_IDX_PWPG, 8'hA5);
		wr(`MWP_IDX_WENA, 8'h40);
		cpu_access <= 1;
		ca(16'h9C00, 7'h20, 6'h17, 6'h29);
		ca(16'hC400, 7'h20, 6'h31, 6'h3F);
		wr(`MWP_IDX_DWPG, 8'h3C);
		wr(`MWP_IDX_SCTL, 8'h30);
		wr(`MWP_IDX_WENA, 8'h80);
		ca(16'h7400, 7'h10, 6'h31, 6'h33);
		ca(16'h9C00, 7'h20, 6'h27, 6'h3F);
		wr(`MWP_IDX_DWPG, 8'hC3);
		ca(16'h7400, 7'h10, 6'h0D, 6'h3C);
		$display("data and program windows done");
		wr(`MWP_IDX_EWPG, 8'h96);
		wr(`MWP_IDX_WENA, 8'h20);
		wr(`MWP_IDX_SCTL1, 8'h08);
		wr(`MWP_IDX_SCTL, 8'h08);
		ca(16'h0500, 7'h08, 6'h16, 6'h3E);
		wr(`MWP_IDX_WLOC, 8'h80);
		ca(16'h0100, 7'h08, 6'h16, 6'h3E);
		ca(16'h0500, 7'h00, 6'h01, 6'h3F);
		wr(`MWP_IDX_SCTL1, 8'h00);
		wr(`MWP_IDX_WENA, 8'h00);
		wr(`MWP_IDX_SCTL, 8'h0F);
		for (int k = 0; k < 6; k++)
			ca(pa[k], ps[k], pa[k][15:10], 6'h3F);
		wr(`MWP_IDX_SCTL, 8'h03);
		ca(16'h0B80, 7'h02, 6'h02, 6'h3F);
		$display("extra window and peripheral selects done");
		wr(`MWP_IDX_SCTL, 8'h60);
		wr(`MWP_IDX_SCTL1, 8'h40);
		ca(16'h1000, 7'h40, 6'h04, 6'h3F);
		ca(16'h9000, 7'h20, 6'h24, 6'h3F);
		wr(`MWP_IDX_SCTL1, 8'h20);
		wr(`MWP_IDX_PWPG, 8'h00);
		wr(`MWP_IDX_WENA, 8'h40);
		ca(16'h8000, 7'h40, 6'h00, 6'h00);
		ca(16'hC000, 7'h20, 6'h30, 6'h3F);
		cpu_access <= 0;
		@(negedge hclk);
		chk("idle", {select_onehot, port_f_out}, {7'h00, 7'h7F});
		@(posedge hclk);
		rd(`MWP_IDX_LASTSEL, 8'h20);
		rd(`MWP_IDX_LASTADR, 8'h3F);
		$display("program selects done");
		wr(`MWP_IDX_PASGN, 8'h00);
		wr(`MWP_IDX_GDIR, 8'h0F);
		wr(`MWP_IDX_GDATA, 8'h05);
		rd(`MWP_IDX_GDATA, 8'h35);
		chk("gio", {port_g_oe, port_g_out & 6'h0F}, 12'h3C5);
		ce <= 0;
		fork
			wr(`MWP_IDX_DWPG, 8'h5A);
			begin
				@(negedge hclk);
				chk("stall", {31'h0, hreadyout}, 32'h0);
				repeat (3) @(posedge hclk);
				ce <= 1;
			end
		join
		rd(`MWP_IDX_DWPG, 8'h5A);
		expanded_mode <= 0;
		cpu_access <= 1;
		wr(`MWP_IDX_PASGN, 8'h3F);
		@(negedge hclk);
		chk("single", {port_g_oe, select_onehot, port_f_out},
			{6'h0F, 7'h00, 7'h7F});
		$display("port and mode checks done");
		complete_run;
	end
endmodule // mwp_top_tb_top
